/* File: gpmi_line.sv */
// One GPIO line: input synchroniser, trigger detection and edge latch
`timescale 1ns/1ps
`default_nettype none
module gpmi_line (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic sense,
  input  wire logic dual_edge,
  input  wire logic polarity,
  input  wire logic clear,
  output logic      level,
  output logic      raw
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic filt_q;
  logic edge_q;
  wire  agree     = (s2_q == s3_q);
  wire  new_level = agree ? s3_q : filt_q;
  wire  rise      = new_level & ~filt_q;
  wire  fall      = ~new_level & filt_q;
  wire  one_edge  = polarity ? rise : fall;
  wire  hit       = ~sense & (dual_edge ? (rise | fall) : one_edge);
  wire  level_hit = (filt_q == polarity);
  // New edge beats a clear in the same cycle so no event is lost
  wire  edge_d    = hit | (edge_q & ~clear);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      filt_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= new_level;
      edge_q <= edge_d;
    end
  end

  assign level = filt_q;
  assign raw   = sense ? level_hit : edge_q;

  a_edge_latch: assert property (@(posedge ref_clk) disable iff (rst)
    (hit) |=> (edge_q ##1 1'b1)) else $error("detected edge not latched");
  a_both_edges: assert property (@(posedge ref_clk) disable iff (rst)
    (~sense & dual_edge & (rise | fall)) |=> edge_q) else $error("both-edge trigger missed");
  a_clear_drops: assert property (@(posedge ref_clk) disable iff (rst)
    (clear & ~hit) |=> ~edge_q) else $error("edge latch not cleared");
  a_zero_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    (edge_q & ~clear) |=> edge_q) else $error("edge latch dropped without clear");
endmodule
`default_nettype wire

/* File: gpmi_params.svh */
// Register offsets, reset values and fixed pin defaults for the masked GPIO port
`ifndef GPMI_PARAMS_SVH
`define GPMI_PARAMS_SVH
`define GPMI_ADDR_W        12
`define GPMI_LINES         8
`define GPMI_OFS_DIR       12'h400
`define GPMI_OFS_SENSE     12'h404
`define GPMI_OFS_DUAL      12'h408
`define GPMI_OFS_POL       12'h40C
`define GPMI_OFS_MASK      12'h410
`define GPMI_OFS_RAW       12'h414
`define GPMI_OFS_MIS       12'h418
`define GPMI_OFS_CLEAR     12'h41C
`define GPMI_OFS_HWSEL     12'h420
`define GPMI_DATA_REGION   2'h0
`define GPMI_RST_REG       8'h00
`define GPMI_RST_WORD      32'h00000000
`define GPMI_DBG_PULL_UP   4'h7
`define GPMI_DBG_PULL_DOWN 4'h8
`endif

/* File: gpmi_pin_model.sv */
// Pin-side model: resolves each line from device drive and outside source
`timescale 1ns/1ps
`default_nettype none
module gpmi_pin_model (
  input  wire logic [7:0] ext_drive,
  input  wire logic [7:0] pin_output,
  input  wire logic [7:0] pin_output_en,
  output logic      [7:0] pin_input
);
  // The outside source yields wherever the device drives, so no line is contended
  assign pin_input = (pin_output & pin_output_en) | (ext_drive & ~pin_output_en);
endmodule
`default_nettype wire

/* File: gpmi_pkg.sv */
// Shared types of the masked GPIO port
package gpmi_pkg;
  typedef logic [7:0] gpmi_lines_type;
  typedef logic [3:0] gpmi_debug_pins_type;
endpackage

/* File: gpmi_top.sv */
// Masked GPIO port: register slave, pin drive and per-line triggers
// Function
// - Data writes change only bits whose address mask bit PADDR[9:2] is one.
// - Data reads return zero where the address mask bit is zero.
// - In software mode a data bit drives its pin only when direction is output.
// - Data reads give written value for outputs, synchronised pin for inputs.
// - Direction register is 8 bits; one means output, zero means input.
// - Reset clears data, direction, sense, dual-edge, polarity and mask registers.
// - Sense bit one selects level detection, zero selects edge detection.
// - Edge mode with dual-edge bit set triggers on both edges, ignoring polarity.
// - Dual-edge bit zero leaves single edge or level polarity to polarity bit.
// - Polarity one means rising or high, zero means falling or low.
// - Mask bit one lets its line interrupt; zero blocks it.
// - After reset debug pins pull up data, mode, reset and pull down clock.
// - Read-only raw status shows trigger detection before masking, cleared by reset.
// - Read-only masked status is exported as eight per-line interrupt outputs.
// - Writing one to the clear register clears that line's edge latch unless a new edge is detected in the same cycle.
// - Hardware select bit one hands the line to hardware; reset gives software.
`timescale 1ns/1ps
`default_nettype none
`include "gpmi_params.svh"
module gpmi_top #(
  parameter int LINES = `GPMI_LINES
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [`GPMI_ADDR_W-1:0]       paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  input  wire logic [LINES-1:0]              pin_input,
  output logic      [LINES-1:0]              pin_output,
  output logic      [LINES-1:0]              pin_output_en,
  input  wire logic [LINES-1:0]              hw_output,
  input  wire logic [LINES-1:0]              hw_output_en,
  output logic      [LINES-1:0]              masked_trigger_status,
  output logic                               combined_line_irq,
  output gpmi_pkg::gpmi_debug_pins_type      debug_pull_up,
  output gpmi_pkg::gpmi_debug_pins_type      debug_pull_down
);
  gpmi_pkg::gpmi_lines_type port_data_q;
  gpmi_pkg::gpmi_lines_type line_direction_q;
  gpmi_pkg::gpmi_lines_type trigger_sense_q;
  gpmi_pkg::gpmi_lines_type dual_edge_q;
  gpmi_pkg::gpmi_lines_type trigger_polarity_q;
  gpmi_pkg::gpmi_lines_type trigger_mask_q;
  gpmi_pkg::gpmi_lines_type hw_control_q;
  gpmi_pkg::gpmi_lines_type mis_q;
  gpmi_pkg::gpmi_lines_type pin_output_q;
  gpmi_pkg::gpmi_lines_type pin_oe_q;
  gpmi_pkg::gpmi_debug_pins_type pull_up_q;
  gpmi_pkg::gpmi_debug_pins_type pull_down_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        irq_q;
  gpmi_pkg::gpmi_lines_type raw_status;
  gpmi_pkg::gpmi_lines_type line_level;

  // Bus decode: writes in the access phase, reads sampled in the setup phase
  wire       wr_en     = psel & penable & pwrite;
  wire       rd_en     = psel & ~penable & ~pwrite;
  wire       in_data   = (paddr[11:10] == `GPMI_DATA_REGION);
  wire [7:0] addr_mask = paddr[9:2];
  wire       wr_data   = wr_en & in_data;
  wire       wr_dir    = wr_en & (paddr == `GPMI_OFS_DIR);
  wire       wr_sense  = wr_en & (paddr == `GPMI_OFS_SENSE);
  wire       wr_dual   = wr_en & (paddr == `GPMI_OFS_DUAL);
  wire       wr_pol    = wr_en & (paddr == `GPMI_OFS_POL);
  wire       wr_mask   = wr_en & (paddr == `GPMI_OFS_MASK);
  wire       wr_clear  = wr_en & (paddr == `GPMI_OFS_CLEAR);
  wire       wr_hwsel  = wr_en & (paddr == `GPMI_OFS_HWSEL);
  wire [7:0] data_d    = (port_data_q & ~addr_mask) | (pwdata[7:0] & addr_mask);
  wire [7:0] data_view = (port_data_q & line_direction_q) | (line_level & ~line_direction_q);
  wire [7:0] clear_hit = wr_clear ? pwdata[7:0] : `GPMI_RST_REG;
  wire [7:0] mis_d     = raw_status & trigger_mask_q;
  wire [7:0] pin_out_d = (port_data_q & ~hw_control_q) | (hw_output & hw_control_q);
  wire [7:0] pin_oe_d  = (line_direction_q & ~hw_control_q) | (hw_output_en & hw_control_q);
  // Unmapped offsets and the write-only clear register read as zero
  wire [7:0] rd_byte =
    in_data                         ? (data_view & addr_mask) :
    (paddr == `GPMI_OFS_DIR)        ? line_direction_q :
    (paddr == `GPMI_OFS_SENSE)      ? trigger_sense_q :
    (paddr == `GPMI_OFS_DUAL)       ? dual_edge_q :
    (paddr == `GPMI_OFS_POL)        ? trigger_polarity_q :
    (paddr == `GPMI_OFS_MASK)       ? trigger_mask_q :
    (paddr == `GPMI_OFS_RAW)        ? raw_status :
    (paddr == `GPMI_OFS_MIS)        ? mis_q :
    (paddr == `GPMI_OFS_HWSEL)      ? hw_control_q : `GPMI_RST_REG;

  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      gpmi_line u_line (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin       (pin_input[gi]),
        .sense     (trigger_sense_q[gi]),
        .dual_edge (dual_edge_q[gi]),
        .polarity  (trigger_polarity_q[gi]),
        .clear     (clear_hit[gi]),
        .level     (line_level[gi]),
        .raw       (raw_status[gi])
      );
    end
  endgenerate

  // Status registers are read-only, so writes to them fall through the decode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_data_q        <= `GPMI_RST_REG;
      line_direction_q   <= `GPMI_RST_REG;
      trigger_sense_q    <= `GPMI_RST_REG;
      dual_edge_q        <= `GPMI_RST_REG;
      trigger_polarity_q <= `GPMI_RST_REG;
      trigger_mask_q     <= `GPMI_RST_REG;
      hw_control_q       <= `GPMI_RST_REG;
    end else begin
      if (wr_data)  port_data_q        <= data_d;
      if (wr_dir)   line_direction_q   <= pwdata[7:0];
      if (wr_sense) trigger_sense_q    <= pwdata[7:0];
      if (wr_dual)  dual_edge_q        <= pwdata[7:0];
      if (wr_pol)   trigger_polarity_q <= pwdata[7:0];
      if (wr_mask)  trigger_mask_q     <= pwdata[7:0];
      if (wr_hwsel) hw_control_q       <= pwdata[7:0];
    end
  end

  // Zero wait states: ready rises on the first edge after reset and stays up
  // Debug pad pulls are fixed constants; no register can change them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mis_q        <= `GPMI_RST_REG;
      irq_q        <= 1'b0;
      pin_output_q <= `GPMI_RST_REG;
      pin_oe_q     <= `GPMI_RST_REG;
      prdata_q     <= `GPMI_RST_WORD;
      pready_q     <= 1'b0;
      pull_up_q    <= `GPMI_DBG_PULL_UP;
      pull_down_q  <= `GPMI_DBG_PULL_DOWN;
    end else begin
      mis_q        <= mis_d;
      irq_q        <= |mis_d;
      pin_output_q <= pin_out_d;
      pin_oe_q     <= pin_oe_d;
      pready_q     <= 1'b1;
      if (rd_en) prdata_q <= {24'h000000, rd_byte};
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pin_output            = pin_output_q;
  assign pin_output_en         = pin_oe_q;
  assign masked_trigger_status = mis_q;
  assign combined_line_irq     = irq_q;
  assign debug_pull_up         = pull_up_q;
  assign debug_pull_down       = pull_down_q;

  a_data_mask_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_data |=> ((port_data_q ^ $past(port_data_q)) & ~$past(addr_mask)) == 8'h00)
    else $error("masked-off data bit changed");
  a_data_mask_read: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_en & in_data) |=> (prdata_q[7:0] & ~$past(addr_mask)) == 8'h00)
    else $error("masked-off data bit read nonzero");
  a_data_read_view: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_en & in_data & (addr_mask == 8'hFF)) |=> prdata_q[7:0] == $past(data_view))
    else $error("data read view wrong");
  a_pin_drive_sw: assert property (@(posedge ref_clk) disable iff (rst)
    (hw_control_q == 8'h00) |=> (pin_oe_q == $past(line_direction_q)) && (pin_output_q == $past(port_data_q)))
    else $error("software pin drive wrong");
  a_level_status: assert property (@(posedge ref_clk) disable iff (rst)
    (raw_status & trigger_sense_q) == (trigger_sense_q & ~(line_level ^ trigger_polarity_q)))
    else $error("level status does not follow pin");
  a_mask_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (trigger_mask_q == 8'h00) [*2] |-> mis_q == 8'h00)
    else $error("masked line raised status");
  a_mis_export: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 mis_q == ($past(raw_status) & $past(trigger_mask_q)))
    else $error("masked status not raw and mask");
  a_irq_combined: assert property (@(posedge ref_clk) disable iff (rst)
    combined_line_irq == (|masked_trigger_status))
    else $error("combined interrupt mismatch");
  a_debug_pulls: assert property (@(posedge ref_clk) disable iff (rst)
    (debug_pull_up == `GPMI_DBG_PULL_UP) && (debug_pull_down == `GPMI_DBG_PULL_DOWN))
    else $error("debug pin pulls wrong");
  // Write checks compare against the bus word rather than the decode
  a_data_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_data |=> port_data_q == $past(port_data_q))
    else $error("data changed without a data write");
  a_dir_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_dir |=> line_direction_q == $past(pwdata[7:0]))
    else $error("direction write lost");
  a_sense_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_sense |=> trigger_sense_q == $past(pwdata[7:0]))
    else $error("sense write lost");
  a_dual_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_dual |=> dual_edge_q == $past(pwdata[7:0]))
    else $error("dual-edge write lost");
  a_pol_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_pol |=> trigger_polarity_q == $past(pwdata[7:0]))
    else $error("polarity write lost");
  a_mask_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mask |=> trigger_mask_q == $past(pwdata[7:0]))
    else $error("mask write lost");
  a_mis_blocked: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (mis_q & ~$past(trigger_mask_q)) == 8'h00)
    else $error("masked line shows in status");
  a_hw_select: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (((pin_output_q ^ $past(hw_output)) | (pin_oe_q ^ $past(hw_output_en))) & $past(hw_control_q)) == 8'h00)
    else $error("hardware line not driven from hardware");
  a_irq_from_raw: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 combined_line_irq == (|($past(raw_status) & $past(trigger_mask_q))))
    else $error("combined interrupt not any unmasked trigger");
  a_clear_decode: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en & (paddr != `GPMI_OFS_CLEAR)) |-> clear_hit == 8'h00)
    else $error("clear applied by another write");
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the masked GPIO port
`timescale 1ns/1ps
`default_nettype none
`include "gpmi_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module testbench;
  logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, exp_v, seed = 29;
  logic [7:0]  drv = 0, pin_in, pout, poen, hw_o = 0, hw_en = 0, mis;
  logic [3:0]  pu, pd;
  logic [31:0] q[$];
  int          errors = 0, n_checks = 0, cyc = 0;

  gpmi_top uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pin_input(pin_in),
    .pin_output(pout), .pin_output_en(poen), .hw_output(hw_o), .hw_output_en(hw_en),
    .masked_trigger_status(mis), .combined_line_irq(irq), .debug_pull_up(pu), .debug_pull_down(pd));
  gpmi_pin_model pm (.ext_drive(drv), .pin_output(pout), .pin_output_en(poen), .pin_input(pin_in));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    psel = 1;
    pwrite = 1;
    paddr = a;
    pwdata = {24'h000000, d};
    @(negedge ref_clk);
    penable = 1;
    @(negedge ref_clk);
    psel = 0;
    penable = 0;
    pwrite = 0;
  endtask

  // Expected value is noted first; the monitor pops it in the access phase
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    q.push_back({24'h000000, e});
    @(negedge ref_clk);
    psel = 1;
    paddr = a;
    @(negedge ref_clk);
    penable = 1;
    @(negedge ref_clk);
    psel = 0;
    penable = 0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task report_and_stop;
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (psel && penable && !pwrite) begin
      exp_v = q.pop_front();
      `CHK(pready, 1'b1)
      `CHK(prdata, exp_v)
    end
  end

  // Whole run needs well under 1000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      report_and_stop();
    end
  end

  initial begin
    waitc(8);
    `CHK(pready, 1'b0)
    `CHK(poen, 8'h00)
    rst = 0;
    waitc(1);
    `CHK(pu, `GPMI_DBG_PULL_UP)
    `CHK(pd, `GPMI_DBG_PULL_DOWN)
    for (int i = 0; i < 9; i++) rd(12'h400 + 12'(4 * i), 8'h00);
    rd(12'h3FC, 8'h00);
    rd(12'h800, 8'h00);
    wr(`GPMI_OFS_DIR, 8'hFF);
    wr(12'h3FC, 8'hA5);
    wr(12'h03C, 8'h00);
    waitc(2);
    `CHK(pout, 8'hA0)
    `CHK(poen, 8'hFF)
    rd(12'h3C0, 8'hA0);
    rd(12'h0CC, 8'h20);
    wr(`GPMI_OFS_DIR, 8'h0F);
    drv = rnd();
    waitc(6);
    rd(12'h3FC, {drv[7:4], 4'h0});
    `CHK(poen, 8'h0F)
    wr(`GPMI_OFS_DIR, 8'h00);
    drv = 8'h00;
    wr(`GPMI_OFS_DUAL, 8'h0F);
    wr(`GPMI_OFS_POL, 8'h30);
    wr(`GPMI_OFS_MASK, 8'hFF);
    waitc(8);
    wr(`GPMI_OFS_CLEAR, 8'hFF);
    drv = 8'hFF;
    waitc(8);
    rd(`GPMI_OFS_RAW, 8'h3F);
    `CHK(mis, 8'h3F)
    `CHK(irq, 1'b1)
    wr(`GPMI_OFS_CLEAR, 8'h0F);
    waitc(2);
    rd(`GPMI_OFS_RAW, 8'h30);
    wr(`GPMI_OFS_CLEAR, 8'hFF);
    drv = 8'h00;
    waitc(8);
    rd(`GPMI_OFS_RAW, 8'hCF);
    wr(`GPMI_OFS_MASK, 8'h00);
    waitc(2);
    `CHK(mis, 8'h00)
    `CHK(irq, 1'b0)
    wr(`GPMI_OFS_SENSE, 8'hFF);
    wr(`GPMI_OFS_POL, 8'hAA);
    wr(`GPMI_OFS_MASK, 8'h3C);
    drv = rnd();
    waitc(8);
    rd(`GPMI_OFS_RAW, ~(drv ^ 8'hAA));
    `CHK(mis, ~(drv ^ 8'hAA) & 8'h3C)
    `CHK(irq, |(~(drv ^ 8'hAA) & 8'h3C))
    hw_o = rnd();
    hw_en = 8'h0F;
    wr(`GPMI_OFS_HWSEL, 8'h0F);
    waitc(2);
    `CHK(pout[3:0], hw_o[3:0])
    `CHK(poen, 8'h0F)
    rd(`GPMI_OFS_HWSEL, 8'h0F);
    waitc(3);
    rst = 1;
    waitc(2);
    `CHK(pready, 1'b0)
    rst = 0;
    waitc(1);
    `CHK(pout, 8'h00)
    rd(`GPMI_OFS_HWSEL, 8'h00);
    rd(`GPMI_OFS_MASK, 8'h00);
    rd(12'h3FC, drv);
    waitc(3);
    report_and_stop();
  end
endmodule
`default_nettype wire
